// ### core/cdp_cfg.svh
// Register map, field positions, reset values and timing counts of the codec digital path
`ifndef CDP_CFG_SVH
`define CDP_CFG_SVH

`define CDP_REG_POWER 8'h00
`define CDP_REG_PATH 8'h04
`define CDP_REG_MIC 8'h08
`define CDP_REG_VOLUME 8'h0c
`define CDP_REG_HP_A 8'h10
`define CDP_REG_HP_B 8'h14
`define CDP_REG_EQ_BASE 8'h18
`define CDP_REG_STATUS 8'h30

`define CDP_PWR_ADC 0
`define CDP_PWR_FILTER 1
`define CDP_PWR_DAC 2
`define CDP_PWR_INIT_LEN 3

`define CDP_PATH_ON_ADC 0
`define CDP_PATH_TO_DAC 1
`define CDP_PATH_TO_SDO 2
`define CDP_PATH_ADC_HP 3
`define CDP_PATH_PRE_HP 4
`define CDP_PATH_EQ1 5
`define CDP_PATH_EQ2 6
`define CDP_PATH_LEVEL 7

`define CDP_MIC_DIFF 3
`define CDP_MIC_BEEP_PWR 4
`define CDP_MIC_BEEP_LINE 5
`define CDP_MIC_BEEP_SPK 6

`define CDP_RST_POWER 16'h0000
`define CDP_RST_PATH 16'h0005
`define CDP_RST_MIC 16'h0001
`define CDP_RST_VOLUME 16'h0091
`define CDP_RST_COEF 16'h0000

`define CDP_INIT_LONG 11'h423
`define CDP_INIT_SHORT 11'h123
`define CDP_ZC_BASE 11'h080
`define CDP_COEF_FRAC 13
`define CDP_VOL_MAX 8'hf1
`define CDP_VOL_EXP_SHIFT 23

`endif

// ### core/cdp_digital_path.sv
// Codec digital path: control registers, ADC init, routing, filters and input volume
`timescale 1ns/1ns
`include "cdp_cfg.svh"
module cdp_digital_path import cdp_pkg::*; (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic power_down_n_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	// Sample stream
	input wire logic fs_tick_i,
	input wire cdp_sample_type adc_sample_i,
	input wire cdp_sample_type dac_in_sample_i,
	output cdp_sample_type serial_out_sample_o,
	output cdp_sample_type dac_out_sample_o,
	output logic sample_strobe_o,
	// Analog front-end controls
	output logic [5:0] mic_gain_db_o,
	output logic mic_diff_o,
	output logic beep_power_o,
	output logic beep_to_line_o,
	output logic beep_to_speaker_o,
	output logic adc_init_busy_o
);
	logic pd_s1_r;
	logic pd_s2_r;
	logic pd_s3_r;
	logic pd_rst_r;
	logic rst;
	logic [15:0] power_r;
	logic [15:0] path_r;
	logic [15:0] mic_r;
	logic [15:0] vol_r;
	logic [13:0] hp_a_r;
	logic [13:0] hp_b_r;
	logic [15:0] eq_coef_r [0:5];
	logic vol_wr;
	logic adc_power_en;
	logic filter_power_en;
	logic adc_init_len_sel;
	logic filter_on_adc_sel;
	logic filter_to_dac_sel;
	logic filter_to_serial_out_sel;
	logic manual_vol;
	cdp_init_state_type init_state_r;
	logic adc_pwr_d_r;
	logic [10:0] init_cnt_r;
	cdp_sample_type adc_gated;
	cdp_sample_type adc_hp;
	cdp_sample_type chain_in;
	cdp_sample_type pre_hp;
	cdp_sample_type eq1_y;
	cdp_sample_type eq2_y;
	cdp_sample_type vol_y_r;
	cdp_sample_type vol_prev_r;
	cdp_sample_type vol_gain_y;
	logic [7:0] applied_code_r;
	logic vol_pend_r;
	logic [10:0] zc_cnt_r;
	logic [10:0] zc_limit;
	logic zero_cross;
	cdp_mode_type mode;
	logic [7:0] vol_n;
	logic [15:0] mant;
	logic signed [47:0] vol_wide;
	logic tick_d_r;

	// Three-stage pin synchroniser; reset decision changes once stages two and three agree
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pd_s1_r <= 1'b1;
			pd_s2_r <= 1'b1;
			pd_s3_r <= 1'b1;
		end else begin
			pd_s1_r <= power_down_n_i;
			pd_s2_r <= pd_s1_r;
			pd_s3_r <= pd_s2_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pd_rst_r <= 1'b0;
		end else if (pd_s2_r == pd_s3_r) begin
			pd_rst_r <= ~pd_s3_r;
		end
	end

	assign rst = reset_i | pd_rst_r;

	// Control registers
	always_ff @(posedge clk_i) begin
		if (rst) begin
			power_r <= `CDP_RST_POWER;
			path_r <= `CDP_RST_PATH;
			mic_r <= `CDP_RST_MIC;
			vol_r <= `CDP_RST_VOLUME;
			hp_a_r <= 14'h0000;
			hp_b_r <= 14'h0000;
			for (int i = 0; i < 6; i++) begin
				eq_coef_r[i] <= `CDP_RST_COEF;
			end
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				`CDP_REG_POWER: power_r <= {12'h000, reg_wdata_i[3:0]};
				`CDP_REG_PATH: path_r <= {8'h00, reg_wdata_i[7:0]};
				`CDP_REG_MIC: mic_r <= {9'h000, reg_wdata_i[6:0]};
				`CDP_REG_VOLUME: vol_r <= {6'h00, reg_wdata_i[9:0]};
				`CDP_REG_HP_A: hp_a_r <= reg_wdata_i[13:0];
				`CDP_REG_HP_B: hp_b_r <= reg_wdata_i[13:0];
				default: begin
					for (int i = 0; i < 6; i++) begin
						if (reg_addr_i == `CDP_REG_EQ_BASE + 8'(4 * i)) begin
							eq_coef_r[i] <= reg_wdata_i;
						end
					end
				end
			endcase
		end
	end

	assign adc_power_en = power_r[`CDP_PWR_ADC];
	assign filter_power_en = power_r[`CDP_PWR_FILTER];
	assign adc_init_len_sel = power_r[`CDP_PWR_INIT_LEN];
	assign filter_on_adc_sel = path_r[`CDP_PATH_ON_ADC];
	assign filter_to_dac_sel = path_r[`CDP_PATH_TO_DAC];
	assign filter_to_serial_out_sel = path_r[`CDP_PATH_TO_SDO];
	assign vol_wr = reg_wr_i && (reg_addr_i == `CDP_REG_VOLUME);

	// Read port: data stands only in the cycle after the strobe, unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`CDP_REG_POWER: reg_rdata_o <= power_r;
				`CDP_REG_PATH: reg_rdata_o <= path_r;
				`CDP_REG_MIC: reg_rdata_o <= mic_r;
				`CDP_REG_VOLUME: reg_rdata_o <= vol_r;
				`CDP_REG_HP_A: reg_rdata_o <= {2'b00, hp_a_r};
				`CDP_REG_HP_B: reg_rdata_o <= {2'b00, hp_b_r};
				`CDP_REG_STATUS: reg_rdata_o <= {applied_code_r, 2'b00, mode, vol_pend_r,
					init_state_r == CDP_INIT_BUSY};
				default: begin
					reg_rdata_o <= 16'h0000;
					for (int i = 0; i < 6; i++) begin
						if (reg_addr_i == `CDP_REG_EQ_BASE + 8'(4 * i)) begin
							reg_rdata_o <= eq_coef_r[i];
						end
					end
				end
			endcase
		end else begin
			reg_rdata_o <= 16'h0000;
		end
	end

	// ADC initialization sequencer
	always_ff @(posedge clk_i) begin
		if (rst) begin
			init_state_r <= CDP_INIT_IDLE;
			adc_pwr_d_r <= 1'b0;
			init_cnt_r <= 11'h000;
		end else begin
			adc_pwr_d_r <= adc_power_en;
			case (init_state_r)
				CDP_INIT_IDLE: begin
					if (adc_power_en && !adc_pwr_d_r) begin
						init_state_r <= CDP_INIT_BUSY;
						init_cnt_r <= adc_init_len_sel ? `CDP_INIT_SHORT : `CDP_INIT_LONG;
					end
				end
				CDP_INIT_BUSY: begin
					if (!adc_power_en) begin
						init_state_r <= CDP_INIT_IDLE;
					end else if (fs_tick_i) begin
						if (init_cnt_r == 11'h001) begin
							init_state_r <= CDP_INIT_RUN;
						end
						init_cnt_r <= init_cnt_r - 11'h001;
					end
				end
				CDP_INIT_RUN: begin
					if (!adc_power_en) begin
						init_state_r <= CDP_INIT_IDLE;
					end
				end
				default: init_state_r <= CDP_INIT_IDLE;
			endcase
		end
	end

	// Zero until the init cycle is over, so start-up offset never reaches the chain
	assign adc_gated = (init_state_r == CDP_INIT_RUN) ? adc_sample_i : 16'sh0000;

	// ADC high-pass, first of the two sections sharing one coefficient pair
	cdp_hpf_section u_adc_hp (
		.clk_i(clk_i),
		.reset_i(rst),
		.tick_i(fs_tick_i),
		.en_i(path_r[`CDP_PATH_ADC_HP] & adc_power_en),
		.coef_a_i(hp_a_r),
		.coef_b_i(hp_b_r),
		.x_i(adc_gated),
		.y_o(adc_hp)
	);

	// Chain source follows the filter-on-ADC bit
	assign chain_in = filter_on_adc_sel ? adc_hp : dac_in_sample_i;

	// High-pass, then band one, then band two, then volume
	cdp_hpf_section u_pre_hp (
		.clk_i(clk_i),
		.reset_i(rst),
		.tick_i(fs_tick_i),
		.en_i(path_r[`CDP_PATH_PRE_HP] & filter_power_en),
		.coef_a_i(hp_a_r),
		.coef_b_i(hp_b_r),
		.x_i(chain_in),
		.y_o(pre_hp)
	);

	cdp_eq_band u_eq1 (
		.clk_i(clk_i),
		.reset_i(rst),
		.tick_i(fs_tick_i),
		.en_i(path_r[`CDP_PATH_EQ1] & filter_power_en),
		.coef_a_i(eq_coef_r[0]),
		.coef_b_i(eq_coef_r[1]),
		.coef_c_i(eq_coef_r[2]),
		.x_i(pre_hp),
		.y_o(eq1_y)
	);

	cdp_eq_band u_eq2 (
		.clk_i(clk_i),
		.reset_i(rst),
		.tick_i(fs_tick_i),
		.en_i(path_r[`CDP_PATH_EQ2] & filter_power_en),
		.coef_a_i(eq_coef_r[3]),
		.coef_b_i(eq_coef_r[4]),
		.coef_c_i(eq_coef_r[5]),
		.x_i(eq1_y),
		.y_o(eq2_y)
	);

	// Manual volume only on the recording side with level control off
	assign manual_vol = filter_on_adc_sel & ~path_r[`CDP_PATH_LEVEL];

	// Gain = 2^((code-91h)/16): mantissa from the low nibble, exponent from the high
	always_comb begin
		vol_n = (applied_code_r > `CDP_VOL_MAX) ? `CDP_VOL_MAX - 8'h01 : applied_code_r - 8'h01;
		case (vol_n[3:0])
			4'h0: mant = 16'h4000;
			4'h1: mant = 16'h42d5;
			4'h2: mant = 16'h45ca;
			4'h3: mant = 16'h48e2;
			4'h4: mant = 16'h4c1c;
			4'h5: mant = 16'h4f7b;
			4'h6: mant = 16'h52ff;
			4'h7: mant = 16'h56ac;
			4'h8: mant = 16'h5a82;
			4'h9: mant = 16'h5e84;
			4'ha: mant = 16'h62b4;
			4'hb: mant = 16'h6712;
			4'hc: mant = 16'h6ba2;
			4'hd: mant = 16'h7066;
			4'he: mant = 16'h7560;
			default: mant = 16'h7a93;
		endcase
		vol_wide = 48'(eq2_y * $signed({1'b0, mant})) <<< vol_n[7:4];
		if (applied_code_r == 8'h00) begin
			vol_gain_y = 16'sh0000;
		end else begin
			vol_gain_y = cdp_sat16(vol_wide >>> `CDP_VOL_EXP_SHIFT);
		end
	end

	// Timeout 128, 256, 512 or 1024 sample periods
	assign zc_limit = `CDP_ZC_BASE << vol_r[9:8];
	assign zero_cross = (eq2_y == 16'sh0000) || (eq2_y[15] != vol_prev_r[15]);

	// Pending volume change; a differing write restarts the wait, a repeat does not
	always_ff @(posedge clk_i) begin
		if (rst) begin
			applied_code_r <= 8'h91;
			vol_pend_r <= 1'b0;
			zc_cnt_r <= 11'h000;
			vol_prev_r <= 16'sh0000;
		end else begin
			if (fs_tick_i) begin
				vol_prev_r <= eq2_y;
			end
			if (vol_wr && (reg_wdata_i[7:0] != vol_r[7:0])) begin
				vol_pend_r <= 1'b1;
				zc_cnt_r <= 11'h000;
			end else if (vol_pend_r && fs_tick_i) begin
				if (zero_cross || (zc_cnt_r >= zc_limit - 11'h001)) begin
					applied_code_r <= vol_r[7:0];
					vol_pend_r <= 1'b0;
					zc_cnt_r <= 11'h000;
				end else begin
					zc_cnt_r <= zc_cnt_r + 11'h001;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst) begin
			vol_y_r <= 16'sh0000;
		end else if (fs_tick_i) begin
			vol_y_r <= manual_vol ? vol_gain_y : eq2_y;
		end
	end

	// Path mode, reported in status
	always_comb begin
		case ({filter_on_adc_sel, filter_to_dac_sel, filter_to_serial_out_sel})
			3'b101: mode = CDP_MODE_RECORD;
			3'b010: mode = CDP_MODE_PLAYBACK;
			3'b111: mode = CDP_MODE_LOOPBACK;
			default: mode = CDP_MODE_OTHER;
		endcase
	end

	// Output routing; the DAC side needs no init and follows its power bit from the next sample slot
	always_ff @(posedge clk_i) begin
		if (rst) begin
			serial_out_sample_o <= 16'sh0000;
			dac_out_sample_o <= 16'sh0000;
			tick_d_r <= 1'b0;
			sample_strobe_o <= 1'b0;
		end else begin
			tick_d_r <= fs_tick_i;
			sample_strobe_o <= tick_d_r;
			if (tick_d_r) begin
				serial_out_sample_o <= filter_to_serial_out_sel ? vol_y_r : adc_hp;
				if (!power_r[`CDP_PWR_DAC]) begin
					dac_out_sample_o <= 16'sh0000;
				end else begin
					dac_out_sample_o <= filter_to_dac_sel ? vol_y_r : dac_in_sample_i;
				end
			end
		end
	end

	// Front-end control outputs
	always_ff @(posedge clk_i) begin
		if (rst) begin
			mic_gain_db_o <= 6'h14;
			mic_diff_o <= 1'b0;
			beep_power_o <= 1'b0;
			beep_to_line_o <= 1'b0;
			beep_to_speaker_o <= 1'b0;
			adc_init_busy_o <= 1'b0;
		end else begin
			case (mic_r[2:0])
				3'h0: mic_gain_db_o <= 6'h00;
				3'h1: mic_gain_db_o <= 6'h14;
				3'h2: mic_gain_db_o <= 6'h1a;
				3'h3: mic_gain_db_o <= 6'h20;
				3'h4: mic_gain_db_o <= 6'h06;
				3'h5: mic_gain_db_o <= 6'h0a;
				3'h6: mic_gain_db_o <= 6'h0e;
				default: mic_gain_db_o <= 6'h11;
			endcase
			// Beep bits passed as written; software must clear them for differential mic
			mic_diff_o <= mic_r[`CDP_MIC_DIFF];
			beep_power_o <= mic_r[`CDP_MIC_BEEP_PWR];
			beep_to_line_o <= mic_r[`CDP_MIC_BEEP_LINE];
			beep_to_speaker_o <= mic_r[`CDP_MIC_BEEP_SPK];
			adc_init_busy_o <= (init_state_r == CDP_INIT_BUSY);
		end
	end

endmodule : cdp_digital_path

// ### core/cdp_eq_band.sv
// One equalizer band: band-pass added to the direct signal
`timescale 1ns/1ns
`include "cdp_cfg.svh"
module cdp_eq_band import cdp_pkg::*; (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Control
	input wire logic tick_i,
	input wire logic en_i,
	input wire logic [15:0] coef_a_i,
	input wire logic [15:0] coef_b_i,
	input wire logic [15:0] coef_c_i,
	// Samples
	input wire cdp_sample_type x_i,
	output cdp_sample_type y_o
);
	logic signed [15:0] x1_r;
	logic signed [15:0] x2_r;
	logic signed [15:0] bp1_r;
	logic signed [15:0] bp2_r;
	logic signed [16:0] diff;
	logic signed [47:0] acc;
	cdp_sample_type bp;

	// bp = A*(x - x2) + B*bp1 + C*bp2, all in Q13
	always_comb begin
		diff = 17'(x_i) - 17'(x2_r);
		acc = 48'($signed(coef_a_i) * diff) + 48'($signed(coef_b_i) * bp1_r)
			+ 48'($signed(coef_c_i) * bp2_r);
		bp = cdp_sat16(acc >>> `CDP_COEF_FRAC);
	end

	// Disabled band passes at 0dB and drops its resonator state
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			x1_r <= 16'sh0000;
			x2_r <= 16'sh0000;
			bp1_r <= 16'sh0000;
			bp2_r <= 16'sh0000;
			y_o <= 16'sh0000;
		end else if (tick_i) begin
			x1_r <= x_i;
			x2_r <= x1_r;
			if (en_i) begin
				bp1_r <= bp;
				bp2_r <= bp1_r;
				y_o <= cdp_sat16(48'(x_i) + 48'(bp));
			end else begin
				bp1_r <= 16'sh0000;
				bp2_r <= 16'sh0000;
				y_o <= x_i;
			end
		end
	end

endmodule : cdp_eq_band

// ### core/cdp_hpf_section.sv
// First-order high-pass section, one sample per tick
`timescale 1ns/1ns
`include "cdp_cfg.svh"
module cdp_hpf_section import cdp_pkg::*; (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Control
	input wire logic tick_i,
	input wire logic en_i,
	input wire logic [13:0] coef_a_i,
	input wire logic [13:0] coef_b_i,
	// Samples
	input wire cdp_sample_type x_i,
	output cdp_sample_type y_o
);
	logic signed [15:0] x_prev_r;
	logic signed [16:0] diff;
	logic signed [47:0] acc;

	// y = A*(x - x_prev) + B*y_prev, coefficients in Q13
	always_comb begin
		diff = 17'(x_i) - 17'(x_prev_r);
		acc = 48'($signed(coef_a_i) * diff) + 48'($signed(coef_b_i) * y_o);
	end

	// Bypass keeps tracking the input so enabling starts on the next tick
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			x_prev_r <= 16'sh0000;
			y_o <= 16'sh0000;
		end else if (tick_i) begin
			x_prev_r <= x_i;
			y_o <= en_i ? cdp_sat16(acc >>> `CDP_COEF_FRAC) : x_i;
		end
	end

endmodule : cdp_hpf_section

// ### core/cdp_pkg.sv
// Types and saturation helper shared by the codec digital path modules
package cdp_pkg;

	typedef logic signed [15:0] cdp_sample_type;

	typedef enum logic [2:0] {
		CDP_INIT_IDLE = 3'b001,
		CDP_INIT_BUSY = 3'b010,
		CDP_INIT_RUN = 3'b100
	} cdp_init_state_type;

	typedef enum logic [3:0] {
		CDP_MODE_RECORD = 4'b0001,
		CDP_MODE_PLAYBACK = 4'b0010,
		CDP_MODE_LOOPBACK = 4'b0100,
		CDP_MODE_OTHER = 4'b1000
	} cdp_mode_type;

	// Clip to the 16-bit sample range instead of wrapping
	function automatic cdp_sample_type cdp_sat16(input logic signed [47:0] v);
		if (v > 48'sh7fff) begin
			cdp_sat16 = 16'sh7fff;
		end else if (v < -48'sh8000) begin
			cdp_sat16 = -16'sh8000;
		end else begin
			cdp_sat16 = v[15:0];
		end
	endfunction : cdp_sat16

endpackage : cdp_pkg

// ### verif/cdp_digital_path_asserts.sv
// Port-level checker for the codec digital path
`timescale 1ns/1ns
`include "cdp_cfg.svh"
module cdp_path_checker import cdp_pkg::*; (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic power_down_n_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_rdata_o,
	// Stream and controls
	input wire logic fs_tick_i,
	input wire cdp_sample_type serial_out_sample_o,
	input wire cdp_sample_type dac_out_sample_o,
	input wire logic sample_strobe_o,
	input wire logic [5:0] mic_gain_db_o,
	input wire logic mic_diff_o,
	input wire logic adc_init_busy_o
);
	localparam logic [47:0] DB_TABLE = {6'h11, 6'h0e, 6'h0a, 6'h06, 6'h20, 6'h1a, 6'h14, 6'h00};
	localparam int LONG_LO = 1057;
	localparam int LONG_HI = 1060;
	localparam int SHORT_LO = 289;
	localparam int SHORT_HI = 292;
	// Pin synchroniser keeps the internal reset alive a few edges after the pin returns
	logic [7:0] pd_r;
	logic [3:0] mic_r;
	logic [11:0] busy_ticks_r;
	wire logic pwr_on_wr = reg_wr_i && reg_addr_i == `CDP_REG_POWER && reg_wdata_i[0];
	always_ff @(posedge clk_i) begin
		pd_r <= {pd_r[6:0], ~power_down_n_i};
	end
	always_ff @(posedge clk_i) begin
		if (reg_wr_i && reg_addr_i == `CDP_REG_MIC) begin
			mic_r <= reg_wdata_i[3:0];
		end
	end
	always_ff @(posedge clk_i) begin
		if (!adc_init_busy_o) begin
			busy_ticks_r <= 12'h000;
		end else if (fs_tick_i) begin
			busy_ticks_r <= busy_ticks_r + 12'h001;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i || pd_r != 8'h00);
	sequence s_mic_wr;
		reg_wr_i && reg_addr_i == `CDP_REG_MIC;
	endsequence
	sequence s_strobe_late;
		##2 sample_strobe_o;
	endsequence
	a_read_data_slot: assert property (reg_rdata_o != 16'h0000 |-> $past(reg_rd_i))
		else $error("read data outside its slot");
	a_strobe_follows_tick: assert property (fs_tick_i |-> s_strobe_late)
		else $error("no strobe two cycles after tick");
	a_strobe_has_tick: assert property (sample_strobe_o |-> $past(fs_tick_i, 2))
		else $error("strobe without tick");
	a_samples_hold: assert property (!sample_strobe_o |->
		$stable(serial_out_sample_o) && $stable(dac_out_sample_o))
		else $error("sample output moved between strobes");
	a_gain_decode: assert property (s_mic_wr |->
		##[1:3] mic_gain_db_o == DB_TABLE[mic_r[2:0]*6 +: 6])
		else $error("mic gain decode wrong");
	a_diff_copy: assert property (s_mic_wr |-> ##[1:3] mic_diff_o == mic_r[3])
		else $error("differential select not copied");
	a_init_start: assert property ($rose(adc_init_busy_o) |->
		$past(pwr_on_wr, 2) || $past(pwr_on_wr, 3) || $past(pwr_on_wr, 4))
		else $error("init began without power-on write");
	a_init_length: assert property ($fell(adc_init_busy_o) |->
		(busy_ticks_r >= LONG_LO && busy_ticks_r <= LONG_HI) ||
		(busy_ticks_r >= SHORT_LO && busy_ticks_r <= SHORT_HI))
		else $error("init length wrong");
endmodule : cdp_path_checker

bind cdp_digital_path cdp_path_checker u_path_checker (
	.clk_i(clk_i), .reset_i(reset_i), .power_down_n_i(power_down_n_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .fs_tick_i(fs_tick_i),
	.serial_out_sample_o(serial_out_sample_o), .dac_out_sample_o(dac_out_sample_o),
	.sample_strobe_o(sample_strobe_o), .mic_gain_db_o(mic_gain_db_o),
	.mic_diff_o(mic_diff_o), .adc_init_busy_o(adc_init_busy_o)
);

// ### verif/cdp_digital_path_tb_top.sv
// Self-checking bench for the codec digital path
`timescale 1ns/1ns
`include "cdp_cfg.svh"
module cdp_digital_path_tb_top import cdp_pkg::*;;
	localparam logic [47:0] DB_TABLE = {6'h11, 6'h0e, 6'h0a, 6'h06, 6'h20, 6'h1a, 6'h14, 6'h00};
	localparam logic [11:0] PATH_SEL = 12'h1d5;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic power_down_n_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h00;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [15:0] reg_rdata_o, st;
	logic fs_tick_i, sample_strobe_o, mic_diff_o, adc_init_busy_o;
	logic beep_power_o, beep_to_line_o, beep_to_speaker_o;
	logic [5:0] mic_gain_db_o;
	cdp_sample_type adc_sample_i, dac_in_sample_i, serial_out_sample_o, dac_out_sample_o;
	cdp_sample_type adc_level = 16'h0400;
	cdp_sample_type dac_level = 16'h0400;
	int mismatches = 0;
	int num_checks = 0;
	int n;
	always #4 clk_i = ~clk_i;
	cdp_digital_path dut (.clk_i(clk_i), .reset_i(reset_i), .power_down_n_i(power_down_n_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .fs_tick_i(fs_tick_i),
		.adc_sample_i(adc_sample_i), .dac_in_sample_i(dac_in_sample_i),
		.serial_out_sample_o(serial_out_sample_o), .dac_out_sample_o(dac_out_sample_o),
		.sample_strobe_o(sample_strobe_o), .mic_gain_db_o(mic_gain_db_o),
		.mic_diff_o(mic_diff_o), .beep_power_o(beep_power_o), .beep_to_line_o(beep_to_line_o),
		.beep_to_speaker_o(beep_to_speaker_o), .adc_init_busy_o(adc_init_busy_o));
	cdp_host_model #(.TICK_PERIOD(6)) host (.clk_i(clk_i), .reset_i(reset_i),
		.adc_level_i(adc_level), .dac_level_i(dac_level), .fs_tick_o(fs_tick_i),
		.adc_sample_o(adc_sample_i), .dac_in_sample_o(dac_in_sample_i));
	task automatic complete_run();
		if (mismatches == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_range(input int got, input int lo, input int hi);
		num_checks++;
		if (got < lo || got > hi) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask : chk_range
	task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask : reg_write
	task automatic reg_check(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		st = reg_rdata_o;
		if (a != `CDP_REG_STATUS) chk(st, exp);
	endtask : reg_check
	task automatic ticks(input int k);
		repeat (k) @(posedge sample_strobe_o);
		#1;
	endtask : ticks
	task automatic check_regs();
		reg_check(`CDP_REG_POWER, 16'h0000);
		reg_check(`CDP_REG_PATH, 16'h0005);
		reg_check(`CDP_REG_MIC, 16'h0001);
		reg_check(`CDP_REG_VOLUME, 16'h0091);
		reg_check(`CDP_REG_HP_A, 16'h0000);
		reg_check(8'h3c, 16'h0000);
		reg_check(`CDP_REG_STATUS, 16'h0000);
		chk(st, 16'h9104);
		chk({10'h000, mic_gain_db_o}, 16'h0014);
	endtask : check_regs
	// Steps the input 0 to 400h and looks for the transient peak, then the settled value
	task automatic probe(input logic rec, input logic [7:0] ca, input logic [15:0] cv,
		input logic [15:0] path, input logic [15:0] pk, input logic [15:0] fin);
		logic seen;
		logic [15:0] y;
		adc_level <= 16'h0000;
		dac_level <= 16'h0000;
		ticks(10);
		reg_write(`CDP_REG_PATH, rec ? 16'h0005 : 16'h0002);
		reg_write(ca, cv);
		reg_write(`CDP_REG_PATH, path);
		ticks(3);
		adc_level <= 16'h0400;
		dac_level <= 16'h0400;
		seen = 1'b0;
		repeat (16) begin
			ticks(1);
			y = rec ? serial_out_sample_o : dac_out_sample_o;
			seen = seen | (y === pk);
		end
		chk({15'h0000, seen}, 16'h0001);
		chk(y, fin);
	endtask : probe
	initial begin
		repeat (40000) @(posedge clk_i);
		mismatches++;
		complete_run();
	end
	initial begin
		repeat (8) @(posedge clk_i);
		reset_i <= 1'b0;
		check_regs();
		for (int g = 0; g < 8; g++) begin
			reg_write(`CDP_REG_MIC, 16'h0070 | 16'(g));
			repeat (3) @(posedge clk_i);
			#1;
			chk({10'h000, mic_gain_db_o}, {10'h000, DB_TABLE[g*6 +: 6]});
			chk({13'h0000, beep_power_o, beep_to_line_o, beep_to_speaker_o}, 16'h0007);
		end
		reg_write(`CDP_REG_MIC, 16'h000b);
		repeat (3) @(posedge clk_i);
		#1;
		chk({12'h000, mic_diff_o, beep_power_o, beep_to_line_o, beep_to_speaker_o}, 16'h0008);
		for (int m = 0; m < 4; m++) begin
			reg_write(`CDP_REG_PATH, {13'h0000, PATH_SEL[m*3 +: 3]});
			reg_check(`CDP_REG_STATUS, 16'h0000);
			chk({12'h000, st[5:2]}, 16'h0001 << m);
		end
		reg_write(`CDP_REG_PATH, 16'h0002);
		reg_write(`CDP_REG_POWER, 16'h0006);
		ticks(8);
		chk(dac_out_sample_o, 16'h0400);
		chk({15'h0000, adc_init_busy_o}, 16'h0000);
		reg_write(`CDP_REG_PATH, 16'h0005);
		for (int s = 1; s >= 0; s--) begin
			reg_write(`CDP_REG_POWER, 16'h0000);
			// Flush the chain so only the forced zeros are seen while init runs
			ticks(8);
			reg_write(`CDP_REG_POWER, {12'h000, s[0], 3'b001});
			n = 0;
			repeat (3) @(posedge clk_i);
			while (adc_init_busy_o === 1'b1) begin
				ticks(1);
				n++;
				chk(serial_out_sample_o, 16'h0000);
			end
			chk_range(n, s ? 289 : 1057, s ? 292 : 1060);
			ticks(8);
			chk(serial_out_sample_o, 16'h0400);
		end
		reg_write(`CDP_REG_POWER, 16'h0007);
		probe(1'b1, `CDP_REG_HP_A, 16'h1000, 16'h001d, 16'h0100, 16'h0000);
		probe(1'b0, `CDP_REG_HP_A, 16'h1000, 16'h0012, 16'h0200, 16'h0000);
		probe(1'b0, `CDP_REG_HP_A, 16'h3000, 16'h0012, 16'hfe00, 16'h0000);
		probe(1'b0, `CDP_REG_EQ_BASE, 16'h1000, 16'h0022, 16'h0600, 16'h0400);
		probe(1'b0, 8'h2c, 16'h0000, 16'h0002, 16'h0400, 16'h0400);
		probe(1'b0, 8'h24, 16'hf000, 16'h0042, 16'h0200, 16'h0400);
		reg_write(`CDP_REG_PATH, 16'h0005);
		ticks(10);
		reg_write(`CDP_REG_VOLUME, 16'h0071);
		ticks(100);
		reg_check(`CDP_REG_STATUS, 16'h0000);
		chk({7'h00, st[15:8], st[1]}, 16'h0123);
		reg_write(`CDP_REG_VOLUME, 16'h0051);
		ticks(100);
		reg_check(`CDP_REG_STATUS, 16'h0000);
		chk({8'h00, st[15:8]}, 16'h0091);
		reg_write(`CDP_REG_VOLUME, 16'h0051);
		ticks(40);
		reg_check(`CDP_REG_STATUS, 16'h0000);
		chk({8'h00, st[15:8]}, 16'h0051);
		ticks(8);
		chk(serial_out_sample_o, 16'h0040);
		reg_write(`CDP_REG_PATH, 16'h0085);
		ticks(8);
		chk(serial_out_sample_o, 16'h0400);
		reg_write(`CDP_REG_PATH, 16'h0005);
		adc_level <= 16'h0000;
		ticks(8);
		reg_write(`CDP_REG_VOLUME, 16'h0000);
		ticks(3);
		reg_check(`CDP_REG_STATUS, 16'h0000);
		chk({8'h00, st[15:8]}, 16'h0000);
		adc_level <= 16'h0400;
		ticks(10);
		chk(serial_out_sample_o, 16'h0000);
		@(posedge clk_i);
		power_down_n_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		power_down_n_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		check_regs();
		complete_run();
	end
endmodule : cdp_digital_path_tb_top

// ### verif/cdp_host_model.sv
// Host-side stream source: sample ticks and words in both directions
`timescale 1ns/1ns
module cdp_host_model import cdp_pkg::*; #(
	parameter int TICK_PERIOD = 6
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Levels chosen by the bench
	input wire cdp_sample_type adc_level_i,
	input wire cdp_sample_type dac_level_i,
	// Stream into the design
	output logic fs_tick_o,
	output cdp_sample_type adc_sample_o,
	output cdp_sample_type dac_in_sample_o
);
	logic [7:0] cnt_r;
	cdp_sample_type adc_r;
	cdp_sample_type dac_r;
	always_ff @(posedge clk_i) begin
		if (reset_i || cnt_r == 8'(TICK_PERIOD - 1)) begin
			cnt_r <= 8'h00;
			adc_r <= adc_level_i;
			dac_r <= dac_level_i;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end
	// Words hold over the tick and the cycle after only; inverted elsewhere so late sampling shows
	always_comb begin
		fs_tick_o = !reset_i && cnt_r == 8'h00;
		adc_sample_o = cnt_r < 8'h02 ? adc_r : ~adc_r;
		dac_in_sample_o = cnt_r < 8'h02 ? dac_r : ~dac_r;
	end
endmodule : cdp_host_model
